// >>> mrem_event_manager.sv
// Operation
// [RL1] no port-write leaves while the device-wide permit bit is clear; resets set
// [RL2] received multicast commands set status bit by value; write one clears; triggers excluded
// [RL3] multicast interrupt request when received command's mask bit set; mask resets 0x01
// [RL4] capture output edges on received or software-requested enabled command
// [RL5] capture lines toggle, only while capture mask bit set; mask resets zero
// [RL6] trigger pin edge sets trigger status bit 15..8; write one clears
// [RL7] enabled trigger pin edge requests matching multicast on every port
// [RL8] software selects commands, writes send bit 8; one request carries every selected command
// [RL9] port bit set on any multicast received on that port; write one clears
// [RL10] port received status drives nothing else
// [RL11] writing one to event generate bit sets matching command status bit
// [RL12] handling ports set reset request status bit on reset symbol; write one clears
// [RL13] reset request interrupts only for ports with interrupt enable set; resets zero
// [RL14] reset request port-writes only for ports with notify enable set; resets zero
// [RL15] read-only group header: next pointer, 4-bit revision, 12-bit kind
// [RL16] multicast interrupt reaches top only with enable bit 26 set
// [RL17] device interrupt line only while device enable bit 0 set
// [RL18] any reset request sets summary bit 27
// [RL19] trigger edges found by comparing the live pins with the registered previous sample
// [RL20] send bit reads zero once requests handed to ports
`timescale 1ns/1ps
`default_nettype none
module mrem_event_manager #(
    parameter int PORTS = 4,
    parameter int CMDS  = 8
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // register port
    input  wire mrem_pkg::mrem_bus_t bus,
    output logic [31:0]           rdata,
    // received multicast symbols, one pulse per symbol
    input  wire logic [PORTS-1:0] mcast_rx_valid,
    input  wire logic [PORTS*3-1:0] mcast_rx_cmd,
    // reset symbols per port, and which ports handle them
    input  wire logic [PORTS-1:0] reset_symbol_rx,
    input  wire logic [PORTS-1:0] reset_handling_en,
    // trigger pins
    input  wire logic [CMDS-1:0]  mcast_trigger_in,
    // send request to every port
    output logic [CMDS-1:0]       mcast_send_cmds,
    output logic                  mcast_send_valid,
    // capture outputs
    output logic [CMDS-1:0]       mcast_capture_out,
    // interrupt and notification
    output logic                  irq,
    output logic [PORTS-1:0]      reset_notify_req,
    output logic                  reset_symbol_summary
);

    // command decode is three bits wide and the reset status field holds eight ports
    if (PORTS < 1 || PORTS > 8 || CMDS != 8) begin : g_param_check
        $error("mrem_event_manager: unsupported PORTS or CMDS");
    end

    typedef struct packed {
        logic             permit;
        logic [7:0]       cmd_rcvd;
        logic [7:0]       cmd_mask;
        logic [7:0]       cap_mask;
        logic [7:0]       trig_stat;
        logic [7:0]       trig_en;
        logic [7:0]       req_cmd;
        logic             req_send;
        logic [PORTS-1:0] port_rcvd;
        logic [PORTS-1:0] rst_rcvd;
        logic [PORTS-1:0] rst_irq_mask;
        logic [PORTS-1:0] rst_notify;
        logic             evt_mcast_en;
        logic             dev_irq_en;
        logic [7:0]       trig_prev;
        logic             trig_primed;
        logic [7:0]       send_cmds;
        logic             send_valid;
        logic [7:0]       cap_out;
        logic             irq;
        logic [PORTS-1:0] notify;
        logic             rst_sum;
        logic [31:0]      rdata;
    } mrem_state_t;

    mrem_state_t st_reg;
    mrem_state_t st_next;

    logic [7:0]       rx_cmds;
    logic [PORTS-1:0] rx_ports;
    logic [7:0]       trig_edge;
    logic [7:0]       sw_req;
    logic [7:0]       w1c8;
    logic [PORTS-1:0] w1cp;
    logic             mcast_irq;
    logic             rst_irq;

    // decode each port's command into a one-hot set
    always_comb begin
        rx_cmds  = '0;
        rx_ports = '0;
        for (int p = 0; p < PORTS; p++) begin
            if (mcast_rx_valid[p]) begin
                rx_cmds[mcast_rx_cmd[p*3 +: 3]] = 1'b1;
                rx_ports[p] = 1'b1;
            end
        end
    end

    always_comb begin
        st_next = st_reg;
        // pins taken as synchronous; one register stage gives the previous sample
        // no previous sample in the first cycle out of reset; pins idling high would
        // otherwise show a false edge there
        trig_edge = st_reg.trig_primed ? (mcast_trigger_in ^ st_reg.trig_prev) : 8'h00; // RL19
        st_next.trig_prev = mcast_trigger_in; // RL19
        st_next.trig_primed = 1'b1;
        sw_req = st_reg.req_send ? st_reg.req_cmd : 8'h00; // RL8
        w1c8 = '0;
        w1cp = '0;

        st_next.req_send   = 1'b0; // RL20
        st_next.send_valid = 1'b0;
        st_next.send_cmds  = '0;
        if (st_reg.req_send || |(trig_edge & st_reg.trig_en)) begin
            st_next.send_valid = 1'b1;
            st_next.send_cmds  = sw_req | (trig_edge & st_reg.trig_en); // RL7 RL8
        end

        // capture lines flip level only while enabled
        st_next.cap_out = st_reg.cap_out ^ ((rx_cmds | sw_req) & st_reg.cap_mask); // RL4 RL5

        if (bus.wr) begin
            unique case (bus.addr)
                mrem_pkg::OFF_NOTIFY_PERMIT:  st_next.permit = bus.wdata[mrem_pkg::BIT_PERMIT];
                mrem_pkg::OFF_CMD_RECEIVED:   w1c8 = bus.wdata[7:0];
                mrem_pkg::OFF_CMD_IRQ_MASK:   st_next.cmd_mask = bus.wdata[7:0];
                mrem_pkg::OFF_CAPTURE_MASK:   st_next.cap_mask = bus.wdata[7:0];
                mrem_pkg::OFF_TRIGGER_CTL: begin
                    st_next.trig_en = bus.wdata[7:0];
                    st_next.trig_stat = st_reg.trig_stat
                        & ~bus.wdata[mrem_pkg::BIT_TRIG_STAT +: 8]; // RL6
                end
                mrem_pkg::OFF_SEND_REQUEST: begin
                    st_next.req_cmd = bus.wdata[7:0];
                    if (bus.wdata[mrem_pkg::BIT_SEND])
                        st_next.req_send = 1'b1; // RL8
                end
                mrem_pkg::OFF_PORT_RECEIVED:  w1cp = bus.wdata[PORTS-1:0]; // RL9
                mrem_pkg::OFF_EVENT_INJECT:   st_next.cmd_rcvd = st_reg.cmd_rcvd | bus.wdata[7:0]; // RL11
                mrem_pkg::OFF_RST_RECEIVED:   st_next.rst_rcvd = st_reg.rst_rcvd & ~bus.wdata[PORTS-1:0]; // RL12
                mrem_pkg::OFF_RST_IRQ_MASK:   st_next.rst_irq_mask = bus.wdata[PORTS-1:0];
                mrem_pkg::OFF_RST_NOTIFY:     st_next.rst_notify = bus.wdata[PORTS-1:0];
                mrem_pkg::OFF_EVT_IRQ_ENABLE: st_next.evt_mcast_en = bus.wdata[mrem_pkg::BIT_MCAST_EN];
                mrem_pkg::OFF_DEV_IRQ_ENABLE: st_next.dev_irq_en = bus.wdata[mrem_pkg::BIT_DEV_IRQ];
                default: ;
            endcase
        end

        // set beats clear in the same cycle; trigger pins never reach cmd_rcvd
        st_next.cmd_rcvd  = (st_next.cmd_rcvd & ~w1c8) | rx_cmds; // RL2
        st_next.port_rcvd = (st_reg.port_rcvd & ~w1cp) | rx_ports; // RL9
        st_next.trig_stat = st_next.trig_stat | trig_edge; // RL6
        st_next.rst_rcvd  = st_next.rst_rcvd | (reset_symbol_rx & reset_handling_en); // RL12

        // port_rcvd feeds no interrupt or notification path
        mcast_irq = |(st_reg.cmd_rcvd & st_reg.cmd_mask) && st_reg.evt_mcast_en; // RL3 RL10 RL16
        rst_irq   = |(st_reg.rst_rcvd & st_reg.rst_irq_mask); // RL13
        st_next.irq     = st_reg.dev_irq_en && (mcast_irq || rst_irq); // RL17
        st_next.notify  = st_reg.permit ? (st_reg.rst_rcvd & st_reg.rst_notify) : '0; // RL1 RL14
        st_next.rst_sum = |st_reg.rst_rcvd; // RL18

        st_next.rdata = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                mrem_pkg::OFF_NOTIFY_PERMIT:  st_next.rdata[mrem_pkg::BIT_PERMIT] = st_reg.permit;
                mrem_pkg::OFF_CMD_RECEIVED:   st_next.rdata[7:0] = st_reg.cmd_rcvd;
                mrem_pkg::OFF_CMD_IRQ_MASK:   st_next.rdata[7:0] = st_reg.cmd_mask;
                mrem_pkg::OFF_CAPTURE_MASK:   st_next.rdata[7:0] = st_reg.cap_mask;
                mrem_pkg::OFF_TRIGGER_CTL:    st_next.rdata[15:0] = {st_reg.trig_stat, st_reg.trig_en};
                mrem_pkg::OFF_SEND_REQUEST: begin
                    st_next.rdata[7:0] = st_reg.req_cmd;
                    st_next.rdata[mrem_pkg::BIT_SEND] = st_reg.req_send; // RL20
                end
                mrem_pkg::OFF_PORT_RECEIVED:  st_next.rdata[PORTS-1:0] = st_reg.port_rcvd;
                mrem_pkg::OFF_RST_RECEIVED:   st_next.rdata[PORTS-1:0] = st_reg.rst_rcvd;
                mrem_pkg::OFF_RST_IRQ_MASK:   st_next.rdata[PORTS-1:0] = st_reg.rst_irq_mask;
                mrem_pkg::OFF_RST_NOTIFY:     st_next.rdata[PORTS-1:0] = st_reg.rst_notify;
                mrem_pkg::OFF_EVT_IRQ_ENABLE: st_next.rdata[mrem_pkg::BIT_MCAST_EN] = st_reg.evt_mcast_en;
                mrem_pkg::OFF_DEV_IRQ_ENABLE: st_next.rdata[mrem_pkg::BIT_DEV_IRQ] = st_reg.dev_irq_en;
                mrem_pkg::OFF_EVT_SUMMARY: begin
                    st_next.rdata[mrem_pkg::BIT_RST_SUM]  = |st_reg.rst_rcvd; // RL18
                    st_next.rdata[mrem_pkg::BIT_MCAST_EN] = mcast_irq;
                end
                mrem_pkg::OFF_GROUP_HEADER:   st_next.rdata = {mrem_pkg::NEXT_GROUP_POINTER,
                    mrem_pkg::GROUP_REVISION, mrem_pkg::GROUP_KIND}; // RL15
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg              <= '0;
            st_reg.permit       <= mrem_pkg::PERMIT_RST; // RL1
            st_reg.cmd_mask     <= mrem_pkg::CMD_MASK_RST; // RL3
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata                = st_reg.rdata;
    assign mcast_send_cmds      = st_reg.send_cmds;
    assign mcast_send_valid     = st_reg.send_valid;
    assign mcast_capture_out    = st_reg.cap_out;
    assign irq                  = st_reg.irq;
    assign reset_notify_req     = st_reg.notify;
    assign reset_symbol_summary = st_reg.rst_sum;

endmodule
`default_nettype wire

// >>> mrem_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module mrem_far_end (
    // clock
    input  wire logic       mclk,
    // link ports and trigger pins facing the block
    output var logic [3:0]  mcast_rx_valid    = 4'h0,
    output var logic [11:0] mcast_rx_cmd      = 12'h000,
    output var logic [3:0]  reset_symbol_rx   = 4'h0,
    output var logic [3:0]  reset_handling_en = 4'h0,
    output var logic [7:0]  mcast_trigger_in  = 8'h00
);
    // one symbol cycle; command lines go stale-inverse so old values never match
    task automatic pulse(input logic [3:0] v, input logic [3:0] r, input logic [11:0] c);
        @(posedge mclk);
        mcast_rx_valid <= v;
        reset_symbol_rx <= r;
        mcast_rx_cmd <= c;
        @(posedge mclk);
        mcast_rx_valid <= 4'h0;
        reset_symbol_rx <= 4'h0;
        mcast_rx_cmd <= ~c;
    endtask
endmodule
`default_nettype wire

// >>> mrem_pkg.sv
package mrem_pkg;

    localparam int ADDR_W = 20;

    // register byte addresses
    localparam logic [19:0] OFF_NOTIFY_PERMIT  = 20'h1b934;
    localparam logic [19:0] OFF_CMD_RECEIVED   = 20'h1b93c;
    localparam logic [19:0] OFF_CMD_IRQ_MASK   = 20'h1b940;
    localparam logic [19:0] OFF_CAPTURE_MASK   = 20'h1b944;
    localparam logic [19:0] OFF_TRIGGER_CTL    = 20'h1b948;
    localparam logic [19:0] OFF_SEND_REQUEST   = 20'h1b94c;
    localparam logic [19:0] OFF_PORT_RECEIVED  = 20'h1b950;
    localparam logic [19:0] OFF_EVENT_INJECT   = 20'h1b95c;
    localparam logic [19:0] OFF_RST_RECEIVED   = 20'h1b960;
    localparam logic [19:0] OFF_RST_IRQ_MASK   = 20'h1b968;
    localparam logic [19:0] OFF_RST_NOTIFY     = 20'h1b970;
    localparam logic [19:0] OFF_GROUP_HEADER   = 20'h1ba00;
    // top-level enables and summary
    localparam logic [19:0] OFF_EVT_IRQ_ENABLE = 20'h1b914;
    localparam logic [19:0] OFF_DEV_IRQ_ENABLE = 20'h1b930;
    localparam logic [19:0] OFF_EVT_SUMMARY    = 20'h1b910;

    // field positions
    localparam int BIT_SEND      = 8;
    localparam int BIT_TRIG_STAT = 8;
    localparam int BIT_MCAST_EN  = 26;
    localparam int BIT_RST_SUM   = 27;
    localparam int BIT_DEV_IRQ   = 0;
    localparam int BIT_PERMIT    = 0;

    // reset values
    localparam logic       PERMIT_RST   = 1'h1;
    localparam logic [7:0] CMD_MASK_RST = 8'h01;

    // group header fields
    localparam logic [15:0] NEXT_GROUP_POINTER = 16'h010d;
    localparam logic [3:0]  GROUP_REVISION     = 4'h0;
    localparam logic [11:0] GROUP_KIND         = 12'h000;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } mrem_bus_t;

endpackage

// >>> mrem_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mrem_properties #(
    parameter int PORTS = 4,
    parameter int CMDS  = 8
) (
    // watched ports of the event manager
    input wire logic                mclk,
    input wire logic                rst,
    input wire mrem_pkg::mrem_bus_t bus,
    input wire logic [31:0]         rdata,
    input wire logic [PORTS-1:0]    mcast_rx_valid,
    input wire logic [PORTS-1:0]    reset_symbol_rx,
    input wire logic [PORTS-1:0]    reset_handling_en,
    input wire logic [CMDS-1:0]     mcast_trigger_in,
    input wire logic [CMDS-1:0]     mcast_send_cmds,
    input wire logic                mcast_send_valid,
    input wire logic [CMDS-1:0]     mcast_capture_out,
    input wire logic                irq,
    input wire logic [PORTS-1:0]    reset_notify_req,
    input wire logic                reset_symbol_summary
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_capture_cause: assert property (
        $changed(mcast_capture_out) |-> mcast_send_valid || $past(|mcast_rx_valid))
        else $error("capture output moved without an event");
    chk_capture_sent: assert property (
        $changed(mcast_capture_out) && !$past(|mcast_rx_valid)
        |-> ((mcast_capture_out ^ $past(mcast_capture_out)) & ~mcast_send_cmds) == '0)
        else $error("capture toggled for a command not sent");
    chk_send_request: assert property (
        bus.wr && bus.addr == mrem_pkg::OFF_SEND_REQUEST && bus.wdata[mrem_pkg::BIT_SEND]
        && |bus.wdata[7:0]
        |-> ##2 (mcast_send_valid
        && (mcast_send_cmds & $past(bus.wdata[7:0], 2)) == $past(bus.wdata[7:0], 2)))
        else $error("software send not handed to the ports");
    chk_send_cause: assert property (
        mcast_send_valid |-> $past(bus.wr && bus.addr == mrem_pkg::OFF_SEND_REQUEST, 2)
        || $past(mcast_trigger_in) != $past(mcast_trigger_in, 2))
        else $error("send pulse without request or pin edge");
    chk_header_read: assert property (
        $past(bus.rd && bus.addr == mrem_pkg::OFF_GROUP_HEADER) |-> rdata == {mrem_pkg::NEXT_GROUP_POINTER,
        mrem_pkg::GROUP_REVISION, mrem_pkg::GROUP_KIND}) else $error("group header value wrong");
    chk_reset_summary: assert property (
        |(reset_symbol_rx & reset_handling_en) |-> ##[1:3] reset_symbol_summary)
        else $error("reset request not summarised");
    chk_notify_cause: assert property (
        $rose(|reset_notify_req) |-> reset_symbol_summary)
        else $error("notify request without reset status");
    chk_permit_off: assert property (
        bus.wr && bus.addr == mrem_pkg::OFF_NOTIFY_PERMIT && !bus.wdata[0] |-> ##2 reset_notify_req == '0)
        else $error("notify request while permit clear");
    chk_irq_off: assert property (
        bus.wr && bus.addr == mrem_pkg::OFF_DEV_IRQ_ENABLE && !bus.wdata[mrem_pkg::BIT_DEV_IRQ]
        |-> ##2 !irq)
        else $error("interrupt line high while device enable clear");
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                mclk, rst, irq, mcast_send_valid, reset_symbol_summary;
    mrem_pkg::mrem_bus_t bus;
    logic [31:0]         rdata;
    logic [11:0]         mcast_rx_cmd;
    logic [7:0]          mcast_trigger_in, mcast_send_cmds, mcast_capture_out;
    logic [3:0]          mcast_rx_valid, reset_symbol_rx, reset_handling_en, reset_notify_req;
    int                  miscompares, checks;
    mrem_event_manager DUT (
        .mclk                 (mclk),
        .rst                  (rst),
        .bus                  (bus),
        .rdata                (rdata),
        .mcast_rx_valid       (mcast_rx_valid),
        .mcast_rx_cmd         (mcast_rx_cmd),
        .reset_symbol_rx      (reset_symbol_rx),
        .reset_handling_en    (reset_handling_en),
        .mcast_trigger_in     (mcast_trigger_in),
        .mcast_send_cmds      (mcast_send_cmds),
        .mcast_send_valid     (mcast_send_valid),
        .mcast_capture_out    (mcast_capture_out),
        .irq                  (irq),
        .reset_notify_req     (reset_notify_req),
        .reset_symbol_summary (reset_symbol_summary)
    );
    mrem_far_end far (
        .mclk              (mclk),
        .mcast_rx_valid    (mcast_rx_valid),
        .mcast_rx_cmd      (mcast_rx_cmd),
        .reset_symbol_rx   (reset_symbol_rx),
        .reset_handling_en (reset_handling_en),
        .mcast_trigger_in  (mcast_trigger_in)
    );
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        miscompares += int'(seen !== exp);
        if (seen !== exp) $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge mclk) bus <= {2'b10, a, d};
        @(posedge mclk) bus <= '0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [31:0] exp);
        @(posedge mclk) bus <= {2'b01, a, 32'h0};
        @(posedge mclk) bus <= '0;
        #1 check(rdata, exp);
    endtask
    // bounded wait for the send pulse
    task automatic await_send(input logic [7:0] exp);
        #1;
        for (int i = 0; i < 4 && mcast_send_valid !== 1'b1; i++) @(posedge mclk) #1;
        check({23'h0, mcast_send_valid, mcast_send_cmds}, {23'h0, 1'b1, exp});
    endtask
    task automatic conclude;
        $display("%0d comparisons, %0d mismatches", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        bus = '0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rd(mrem_pkg::OFF_NOTIFY_PERMIT, 32'h1);
        rd(mrem_pkg::OFF_CMD_IRQ_MASK, 32'h1);
        rd(mrem_pkg::OFF_RST_NOTIFY, 32'h0);
        wr(mrem_pkg::OFF_GROUP_HEADER, 32'hffffffff);
        rd(mrem_pkg::OFF_GROUP_HEADER, 32'h010d0000);
        rd(20'h1b938, 32'h0);
        $display("test reset values done");
        far.pulse(4'h5, 4'h0, 12'h0c7);
        rd(mrem_pkg::OFF_CMD_RECEIVED, 32'h88);
        wr(mrem_pkg::OFF_CMD_IRQ_MASK, 32'h08);
        wr(mrem_pkg::OFF_DEV_IRQ_ENABLE, 32'h1);
        rd(mrem_pkg::OFF_PORT_RECEIVED, 32'h5);
        check(32'(irq), 32'h0);
        wr(mrem_pkg::OFF_EVT_IRQ_ENABLE, 32'h04000000);
        wr(mrem_pkg::OFF_PORT_RECEIVED, 32'h1);
        rd(mrem_pkg::OFF_PORT_RECEIVED, 32'h4);
        check(32'(irq), 32'h1);
        rd(mrem_pkg::OFF_EVT_SUMMARY, 32'h04000000);
        wr(mrem_pkg::OFF_CMD_RECEIVED, 32'h08);
        wr(mrem_pkg::OFF_EVENT_INJECT, 32'h41);
        rd(mrem_pkg::OFF_CMD_RECEIVED, 32'hc1);
        check(32'(irq), 32'h0);
        wr(mrem_pkg::OFF_CMD_RECEIVED, 32'hff);
        $display("test received commands done");
        wr(mrem_pkg::OFF_CAPTURE_MASK, 32'h05);
        wr(mrem_pkg::OFF_SEND_REQUEST, 32'h107);
        await_send(8'h07);
        check(32'(mcast_capture_out), 32'h05);
        rd(mrem_pkg::OFF_SEND_REQUEST, 32'h07);
        far.pulse(4'ha, 4'h0, 12'h210);
        rd(mrem_pkg::OFF_CMD_RECEIVED, 32'h06);
        check(32'(mcast_capture_out), 32'h01);
        wr(mrem_pkg::OFF_TRIGGER_CTL, 32'h02);
        far.mcast_trigger_in <= 8'h02;
        await_send(8'h02);
        far.mcast_trigger_in <= 8'h12;
        rd(mrem_pkg::OFF_TRIGGER_CTL, 32'h1202);
        check(32'(mcast_capture_out), 32'h01);
        wr(mrem_pkg::OFF_TRIGGER_CTL, 32'h0202);
        rd(mrem_pkg::OFF_TRIGGER_CTL, 32'h1002);
        rd(mrem_pkg::OFF_CMD_RECEIVED, 32'h06);
        $display("test sending done");
        far.reset_handling_en <= 4'h2;
        far.pulse(4'h0, 4'ha, 12'h000);
        rd(mrem_pkg::OFF_RST_RECEIVED, 32'h2);
        check({30'h0, reset_symbol_summary, irq}, 32'h2);
        wr(mrem_pkg::OFF_RST_NOTIFY, 32'h2);
        wr(mrem_pkg::OFF_RST_IRQ_MASK, 32'h2);
        rd(mrem_pkg::OFF_RST_IRQ_MASK, 32'h2);
        check({27'h0, irq, reset_notify_req}, 32'h12);
        wr(mrem_pkg::OFF_NOTIFY_PERMIT, 32'h0);
        rd(mrem_pkg::OFF_NOTIFY_PERMIT, 32'h0);
        check(32'(reset_notify_req), 32'h0);
        wr(mrem_pkg::OFF_DEV_IRQ_ENABLE, 32'h0);
        rd(mrem_pkg::OFF_DEV_IRQ_ENABLE, 32'h0);
        check(32'(irq), 32'h0);
        wr(mrem_pkg::OFF_DEV_IRQ_ENABLE, 32'h1);
        rd(mrem_pkg::OFF_EVT_SUMMARY, 32'h08000000);
        check(32'(irq), 32'h1);
        wr(mrem_pkg::OFF_RST_RECEIVED, 32'h2);
        rd(mrem_pkg::OFF_RST_RECEIVED, 32'h0);
        check({30'h0, reset_symbol_summary, irq}, 32'h0);
        $display("test reset requests done");
        conclude();
    end
endmodule
bind mrem_event_manager mrem_properties #(.PORTS(PORTS), .CMDS(CMDS)) chk (
    .mclk                 (mclk),
    .rst                  (rst),
    .bus                  (bus),
    .rdata                (rdata),
    .mcast_rx_valid       (mcast_rx_valid),
    .reset_symbol_rx      (reset_symbol_rx),
    .reset_handling_en    (reset_handling_en),
    .mcast_trigger_in     (mcast_trigger_in),
    .mcast_send_cmds      (mcast_send_cmds),
    .mcast_send_valid     (mcast_send_valid),
    .mcast_capture_out    (mcast_capture_out),
    .irq                  (irq),
    .reset_notify_req     (reset_notify_req),
    .reset_symbol_summary (reset_symbol_summary)
);
`default_nettype wire
